// ===== bcc_chain_top.sv
// Boundary-scan test logic: tap_state_machine, instruction, bypass, boundary_chain
//
// Local design decisions: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// Operation
// - Capture loads the selected instruction or data register in parallel.
// - Shift moves captured bits out toward tdo while taking new tdi bits.
// - Update loads the instruction latch or the chain update flops.
// - Host presents tms with tck; next tap state comes only from sampled tms.
// - Each io_cell_group holds four pad cells linked serially into the chain.
// - In normal operation pads and core pass values untouched by the cells.
// - Each cell has data and direction parts, each shift flop into update flop.
// - Data shift flop feeds direction shift flop inside the chain path.
// - Direction low captures pad input; high captures core output data.
// - Mode from instruction; high lets update data drive pads, low core data.
// - Tms and tdi sampled on tck rise; tdo changes only on tck fall.
// - Under EXTEST chain values reach the pads on the tck falling edge.
// - Cells are sequenced only by capture, update, shift_n, treset, tck, mode.
// - Three-bit instruction; EXTEST 000, SAMPLE 100, BYPASS 111, 011 reserved.
// - Under BYPASS tdi passes one flip-flop to tdo.
// - The tap_state_machine has the sixteen standard states.
module bcc_chain_top (
  input wire logic clk,
  input wire logic rst_n,
  // Test port pins
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  // Pads of the io_cell_group
  input wire logic [bcc_pkg::GROUP_PADS-1:0] pad_in,
  output logic [bcc_pkg::GROUP_PADS-1:0] pad_out,
  output logic [bcc_pkg::GROUP_PADS-1:0] pad_oe,
  // Logic array side
  input wire logic [bcc_pkg::GROUP_PADS-1:0] core_out,
  input wire logic [bcc_pkg::GROUP_PADS-1:0] core_oe,
  output logic [bcc_pkg::GROUP_PADS-1:0] core_in,
  // Avalon-MM slave
  input wire logic [bcc_pkg::AV_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [bcc_pkg::AV_DATA_W-1:0] avs_writedata,
  output logic [bcc_pkg::AV_DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  // Snapshot buffer can take another update
  output logic log_ready
);

  ////////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic tck_m;
    logic tck_s;
    logic tck_d;
    logic tms_m;
    logic tms_s;
    logic tdi_m;
    logic tdi_s;
    logic [bcc_pkg::GROUP_PADS-1:0] pad_m;
    logic [bcc_pkg::GROUP_PADS-1:0] pad_s;
    bcc_pkg::bcc_tap_e tap;
    logic [bcc_pkg::IR_W-1:0] ir_sh;
    logic [bcc_pkg::IR_W-1:0] ir;
    logic byp;
    logic tdo;
    logic tdo_oe;
    logic served;
    logic [bcc_pkg::AV_DATA_W-1:0] rdata;
    logic log_en;
  } bcc_top_s;

  bcc_top_s s;
  bcc_top_s next_s;

  logic tck_rise;
  logic tck_fall;
  logic chain_sel;
  logic mode;
  bcc_pkg::bcc_cell_ctl_s ctl;
  logic [bcc_pkg::GROUP_PADS:0] link;
  logic [bcc_pkg::CHAIN_LEN-1:0] chain_bits;
  bcc_pkg::bcc_pad_drv_s [bcc_pkg::GROUP_PADS-1:0] drv;
  logic av_req;
  logic av_take;
  logic log_push;
  logic log_pop;
  logic log_valid;
  logic [bcc_pkg::CHAIN_LEN-1:0] log_data;
  logic [bcc_pkg::LOG_LEVEL_W-1:0] log_level;

  ////////////////////////////////////////////////////////////////////////////////
  // Standard sixteen-state walk, driven by sampled tms alone
  function automatic bcc_pkg::bcc_tap_e tap_next(input bcc_pkg::bcc_tap_e st,
                                                 input logic t);
    unique case (st)
      bcc_pkg::TAP_RESET: tap_next = t ? bcc_pkg::TAP_RESET : bcc_pkg::TAP_IDLE;
      bcc_pkg::TAP_IDLE: tap_next = t ? bcc_pkg::TAP_SEL_DR : bcc_pkg::TAP_IDLE;
      bcc_pkg::TAP_SEL_DR: tap_next = t ? bcc_pkg::TAP_SEL_IR : bcc_pkg::TAP_CAP_DR;
      bcc_pkg::TAP_CAP_DR: tap_next = t ? bcc_pkg::TAP_EX1_DR : bcc_pkg::TAP_SH_DR;
      bcc_pkg::TAP_SH_DR: tap_next = t ? bcc_pkg::TAP_EX1_DR : bcc_pkg::TAP_SH_DR;
      bcc_pkg::TAP_EX1_DR: tap_next = t ? bcc_pkg::TAP_UP_DR : bcc_pkg::TAP_PA_DR;
      bcc_pkg::TAP_PA_DR: tap_next = t ? bcc_pkg::TAP_EX2_DR : bcc_pkg::TAP_PA_DR;
      bcc_pkg::TAP_EX2_DR: tap_next = t ? bcc_pkg::TAP_UP_DR : bcc_pkg::TAP_SH_DR;
      bcc_pkg::TAP_UP_DR: tap_next = t ? bcc_pkg::TAP_SEL_DR : bcc_pkg::TAP_IDLE;
      bcc_pkg::TAP_SEL_IR: tap_next = t ? bcc_pkg::TAP_RESET : bcc_pkg::TAP_CAP_IR;
      bcc_pkg::TAP_CAP_IR: tap_next = t ? bcc_pkg::TAP_EX1_IR : bcc_pkg::TAP_SH_IR;
      bcc_pkg::TAP_SH_IR: tap_next = t ? bcc_pkg::TAP_EX1_IR : bcc_pkg::TAP_SH_IR;
      bcc_pkg::TAP_EX1_IR: tap_next = t ? bcc_pkg::TAP_UP_IR : bcc_pkg::TAP_PA_IR;
      bcc_pkg::TAP_PA_IR: tap_next = t ? bcc_pkg::TAP_EX2_IR : bcc_pkg::TAP_PA_IR;
      bcc_pkg::TAP_EX2_IR: tap_next = t ? bcc_pkg::TAP_UP_IR : bcc_pkg::TAP_SH_IR;
      bcc_pkg::TAP_UP_IR: tap_next = t ? bcc_pkg::TAP_SEL_DR : bcc_pkg::TAP_IDLE;
    endcase
  endfunction : tap_next

  ////////////////////////////////////////////////////////////////////////////////
  // Edge finding on the synchronised test clock; tms and tdi share its latency
  assign tck_rise = s.tck_s && !s.tck_d;
  assign tck_fall = !s.tck_s && s.tck_d;

  assign chain_sel = bcc_pkg::bcc_chain_sel(s.ir);
  assign mode = (s.ir == bcc_pkg::INSTR_EXTEST);

  // Capture, shift and update are levels from the tap state, gated by the chain selection; treset is not gated
  assign ctl.tck_rise = tck_rise;
  assign ctl.tck_fall = tck_fall;
  assign ctl.capture = chain_sel && (s.tap == bcc_pkg::TAP_CAP_DR);
  assign ctl.shift_n = !(chain_sel && (s.tap == bcc_pkg::TAP_SH_DR));
  assign ctl.update = chain_sel && (s.tap == bcc_pkg::TAP_UP_DR);
  assign ctl.treset = (s.tap == bcc_pkg::TAP_RESET);
  assign ctl.mode = mode;

  ////////////////////////////////////////////////////////////////////////////////
  // Boundary chain: cell 0 nearest tdi, last cell feeds tdo
  assign link[0] = s.tdi_s;

  for (genvar i = 0; i < bcc_pkg::GROUP_PADS; i++) begin : g_cell
    bcc_pad_cell u_cell (
      .clk(clk),
      .rst_n(rst_n),
      .ctl(ctl),
      .scan_in(link[i]),
      .core_out(core_out[i]),
      .core_oe(core_oe[i]),
      .pad_in(s.pad_s[i]),
      .scan_out(link[i+1]),
      .shift_pair(chain_bits[2*i +: 2]),
      .drv(drv[i])
    );
    assign pad_out[i] = drv[i].pad_out;
    assign pad_oe[i] = drv[i].pad_oe;
    assign core_in[i] = drv[i].core_in;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Snapshot of the chain at each update, kept for software when enabled.
  // The tap cannot be held off, so a full buffer drops the snapshot; log_ready
  // tells the outside when that would happen.
  assign log_push = s.log_en && tck_fall && ctl.update;
  assign av_req = avs_read || avs_write;
  assign av_take = av_req && s.served;
  assign log_pop = av_take && avs_read && (avs_address == bcc_pkg::REG_LOG);

  bcc_log_fifo #(
    .WIDTH(bcc_pkg::CHAIN_LEN),
    .DEPTH(bcc_pkg::LOG_DEPTH),
    .LW(bcc_pkg::LOG_LEVEL_W)
  ) u_log (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(log_push),
    .in_ready(log_ready),
    .in_data(chain_bits),
    .out_valid(log_valid),
    .out_ready(log_pop),
    .out_data(log_data),
    .level(log_level)
  );

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    // Two-stage synchronisers for everything from the pins
    next_s.tck_m = tck;
    next_s.tck_s = s.tck_m;
    next_s.tck_d = s.tck_s;
    next_s.tms_m = tms;
    next_s.tms_s = s.tms_m;
    next_s.tdi_m = tdi;
    next_s.tdi_s = s.tdi_m;
    next_s.pad_m = pad_in;
    next_s.pad_s = s.pad_m;

    if (tck_rise) begin
      next_s.tap = tap_next(s.tap, s.tms_s);
      unique case (s.tap)
        bcc_pkg::TAP_CAP_IR: next_s.ir_sh = bcc_pkg::IR_CAPTURE_VAL;
        bcc_pkg::TAP_SH_IR: next_s.ir_sh = {s.tdi_s, s.ir_sh[bcc_pkg::IR_W-1:1]};
        bcc_pkg::TAP_CAP_DR: next_s.byp = bcc_pkg::BYPASS_CAPTURE_VAL;
        bcc_pkg::TAP_SH_DR: next_s.byp = s.tdi_s;
        default: next_s.byp = s.byp;
      endcase
    end

    if (tck_fall) begin
      if (s.tap == bcc_pkg::TAP_UP_IR) begin
        next_s.ir = s.ir_sh;
      end
      // Output only moves on the falling test clock
      next_s.tdo_oe = (s.tap == bcc_pkg::TAP_SH_DR) || (s.tap == bcc_pkg::TAP_SH_IR);
      if (s.tap == bcc_pkg::TAP_SH_IR) begin
        next_s.tdo = s.ir_sh[0];
      end else if (s.tap == bcc_pkg::TAP_SH_DR) begin
        next_s.tdo = chain_sel ? link[bcc_pkg::GROUP_PADS] : s.byp;
      end
    end

    // Test-logic reset parks the instruction on BYPASS, which drops mode
    if (s.tap == bcc_pkg::TAP_RESET) begin
      next_s.ir = bcc_pkg::INSTR_BYPASS;
    end

    // Bus slave: one wait cycle, then the access is taken
    next_s.served = av_req && !s.served;
    if (av_req && !s.served && avs_read) begin
      next_s.rdata = '0;
      unique case (avs_address)
        bcc_pkg::REG_STATUS: begin
          next_s.rdata[bcc_pkg::STAT_TAP_LSB +: 4] = s.tap;
          next_s.rdata[bcc_pkg::STAT_IR_LSB +: bcc_pkg::IR_W] = s.ir;
          next_s.rdata[bcc_pkg::STAT_MODE_BIT] = mode;
          next_s.rdata[bcc_pkg::STAT_LEVEL_LSB +: bcc_pkg::LOG_LEVEL_W] = log_level;
          next_s.rdata[bcc_pkg::STAT_TDO_OE_BIT] = s.tdo_oe;
        end
        bcc_pkg::REG_LOG: begin
          next_s.rdata[bcc_pkg::CHAIN_LEN-1:0] = log_valid ? log_data : '0;
          next_s.rdata[bcc_pkg::LOG_VALID_BIT] = log_valid;
        end
        bcc_pkg::REG_CTRL: begin
          next_s.rdata[bcc_pkg::CTRL_LOG_EN_BIT] = s.log_en;
        end
        default: next_s.rdata = '0;
      endcase
    end
    if (av_take && avs_write && (avs_address == bcc_pkg::REG_CTRL)) begin
      next_s.log_en = avs_writedata[bcc_pkg::CTRL_LOG_EN_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
      s.tap <= bcc_pkg::TAP_RESET;
      s.ir <= bcc_pkg::INSTR_BYPASS;
      s.log_en <= bcc_pkg::CTRL_LOG_EN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign tdo = s.tdo;
  assign tdo_oe = s.tdo_oe;
  assign avs_readdata = s.rdata;
  assign avs_waitrequest = av_req && !s.served;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks sample every clk; the edge checks look one clk after a detected test clock edge
  a_tdo_on_fall : assert property (@(posedge clk) disable iff (!rst_n)
    ($changed(tdo) || $changed(tdo_oe)) |-> $past(tck_fall))
    else $error("tdo moved away from a falling test clock");

  a_reset_holds : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_RESET) && s.tms_s) |=>
      (s.tap == bcc_pkg::TAP_RESET))
    else $error("tap left reset with tms high");

  a_idle_walk : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_IDLE)) |=>
      (s.tap == ($past(s.tms_s) ? bcc_pkg::TAP_SEL_DR : bcc_pkg::TAP_IDLE)))
    else $error("tap left idle against tms");

  a_tms_walk : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_SEL_DR) && !s.tms_s) |=>
      (s.tap == bcc_pkg::TAP_CAP_DR) ##1 (s.tap == bcc_pkg::TAP_CAP_DR))
    else $error("tap did not enter capture-dr");

  a_tap_still : assert property (@(posedge clk) disable iff (!rst_n)
    !tck_rise |=> $stable(s.tap))
    else $error("tap changed without a rising test clock");

  a_mode_reset : assert property (@(posedge clk) disable iff (!rst_n)
    (s.tap == bcc_pkg::TAP_RESET) |=> !mode)
    else $error("mode high after test-logic reset");

  a_ir_capture : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_CAP_IR)) |=>
      (s.ir_sh == bcc_pkg::IR_CAPTURE_VAL))
    else $error("instruction capture value wrong");

  a_ir_update : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && (s.tap == bcc_pkg::TAP_UP_IR)) |=> (s.ir == $past(s.ir_sh)))
    else $error("instruction latch not updated");

  // The latch may only move at an update fall or in test-logic reset
  a_ir_hold : assert property (@(posedge clk) disable iff (!rst_n)
    !(tck_fall && (s.tap == bcc_pkg::TAP_UP_IR)) && (s.tap != bcc_pkg::TAP_RESET)
      |=> $stable(s.ir))
    else $error("instruction latch moved outside update");

  a_ir_shift_in : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_SH_IR)) |=>
      (s.ir_sh[bcc_pkg::IR_W-1] == $past(s.tdi_s)))
    else $error("instruction shifter did not take tdi");

  a_bypass_one : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_rise && (s.tap == bcc_pkg::TAP_SH_DR) && !chain_sel) |=>
      (s.byp == $past(s.tdi_s)))
    else $error("bypass flop did not take tdi");

  a_bypass_out : assert property (@(posedge clk) disable iff (!rst_n)
    (tck_fall && (s.tap == bcc_pkg::TAP_SH_DR) && !chain_sel) |=> (tdo == $past(s.byp)))
    else $error("bypass flop did not reach tdo");

  a_tdo_oe_shift : assert property (@(posedge clk) disable iff (!rst_n)
    $rose(tdo_oe) |->
      ($past(s.tap) == bcc_pkg::TAP_SH_DR) || ($past(s.tap) == bcc_pkg::TAP_SH_IR))
    else $error("tdo enabled outside a shift state");

  // Under EXTEST the pads hold the update flops; core activity must not leak out
  a_mode_decode : assert property (@(posedge clk) disable iff (!rst_n)
    (mode && $past(mode) && !$past(tck_fall)) |-> $stable(pad_out) && $stable(pad_oe))
    else $error("pads followed the core while in EXTEST");

  a_treset_pads : assert property (@(posedge clk) disable iff (!rst_n)
    ctl.treset |=> (pad_out == core_out) && (pad_oe == core_oe))
    else $error("pads not back to functional use after test-logic reset");

  a_normal_pass : assert property (@(posedge clk) disable iff (!rst_n)
    !mode |-> (pad_out == core_out) && (pad_oe == core_oe) && (core_in == s.pad_s))
    else $error("functional path disturbed in normal operation");
endmodule : bcc_chain_top

// ===== bcc_host.sv
// Test host model: makes the test clock and walks the tap over tms and tdi
`timescale 1ns/10ps
module bcc_host (
  input wire logic clk,
  input wire logic tdo,
  input wire logic tdo_oe,
  output logic tck,
  output logic tms,
  output logic tdi
);
  // Clock stands still between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One test clock period of 8 clk, 200 ns, well under the speed limit
  task automatic step(input logic m, input logic d, output logic o);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (4) @(posedge clk);
    tck <= 1'b1;
    repeat (3) @(posedge clk);
    // Late in the high phase, so the bit launched at the fall has settled
    // An undriven line reads inverted, so a missing enable cannot go unseen
    o = tdo_oe ? tdo : !tdo;
  endtask : step
endmodule : bcc_host

// ===== bcc_log_fifo.sv
// Small synchronous FIFO holding boundary chain snapshots
`timescale 1ns/10ps
module bcc_log_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int LW = 3
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [LW-1:0] level
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wr;
    logic [PW-1:0] rd;
    logic [LW-1:0] cnt;
  } bcc_fifo_s;

  bcc_fifo_s s;
  bcc_fifo_s next_s;
  logic push;
  logic pop;

  function automatic logic [PW-1:0] bump(input logic [PW-1:0] p);
    return (p == PW'(DEPTH - 1)) ? '0 : PW'(p + 1'b1);
  endfunction : bump

  assign in_ready = (s.cnt != LW'(DEPTH));
  assign out_valid = (s.cnt != '0);
  assign out_data = s.mem[s.rd];
  assign level = s.cnt;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr = bump(s.wr);
    end
    if (pop) begin
      next_s.rd = bump(s.rd);
    end
    next_s.cnt = LW'(s.cnt + LW'(push) - LW'(pop));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : bcc_log_fifo

// ===== bcc_pad_cell.sv
// One pad_scan_cell: data cell and direction cell, each shift plus update flop
`timescale 1ns/10ps
module bcc_pad_cell (
  input wire logic clk,
  input wire logic rst_n,
  input wire bcc_pkg::bcc_cell_ctl_s ctl,
  input wire logic scan_in,
  input wire logic core_out,
  input wire logic core_oe,
  input wire logic pad_in,
  output logic scan_out,
  output logic [1:0] shift_pair,
  output bcc_pkg::bcc_pad_drv_s drv
);
  typedef struct packed {
    logic data_sh;
    logic dir_sh;
    logic data_upd;
    logic dir_upd;
  } bcc_cell_s;

  bcc_cell_s s;
  bcc_cell_s next_s;
  logic direction_select;

  // High means the pad is driving out
  assign direction_select = ctl.mode ? s.dir_upd : core_oe;

  always_comb begin
    next_s = s;
    if (ctl.tck_rise && ctl.capture) begin
      next_s.data_sh = direction_select ? core_out : pad_in;
      // The direction cell observes what really steers the pad, test or core
      next_s.dir_sh = direction_select;
    end else if (ctl.tck_rise && !ctl.shift_n) begin
      next_s.data_sh = scan_in;
      next_s.dir_sh = s.data_sh;
    end
    if (ctl.tck_fall && ctl.update) begin
      next_s.data_upd = s.data_sh;
      next_s.dir_upd = s.dir_sh;
    end
    if (ctl.treset) begin
      next_s.data_upd = 1'b0;
      next_s.dir_upd = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign scan_out = s.dir_sh;
  assign shift_pair = {s.dir_sh, s.data_sh};
  assign drv.pad_out = ctl.mode ? s.data_upd : core_out;
  assign drv.pad_oe = ctl.mode ? s.dir_upd : core_oe;
  assign drv.core_in = pad_in;

  a_shift_path : assert property (@(posedge clk) disable iff (!rst_n)
    (ctl.tck_rise && !ctl.capture && !ctl.shift_n) |=>
      (s.data_sh == $past(scan_in)) && (s.dir_sh == $past(s.data_sh)))
    else $error("scan cell shift path broken");

  a_capture_dir : assert property (@(posedge clk) disable iff (!rst_n)
    (ctl.tck_rise && ctl.capture) |=>
      (s.data_sh == ($past(direction_select) ? $past(core_out) : $past(pad_in))) &&
      (s.dir_sh == $past(direction_select)))
    else $error("data cell captured the wrong source");

  a_pad_on_fall : assert property (@(posedge clk) disable iff (!rst_n)
    (ctl.mode && $past(ctl.mode) && $changed(s.data_upd) && !$past(ctl.treset))
      |-> $past(ctl.tck_fall))
    else $error("pad test data changed away from a falling test clock");
endmodule : bcc_pad_cell

// ===== bcc_pkg.sv
// Shared constants, types and decode helpers of the boundary cell chain
package bcc_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Chain geometry: one io_cell_group of four pads, two cells per pad
  localparam int GROUP_PADS = 4;
  localparam int CHAIN_LEN = 2 * GROUP_PADS;
  localparam int IR_W = 3;

  // Instruction codes
  localparam logic [IR_W-1:0] INSTR_EXTEST = 3'h0;
  localparam logic [IR_W-1:0] INSTR_RESERVED = 3'h3;
  localparam logic [IR_W-1:0] INSTR_SAMPLE = 3'h4;
  localparam logic [IR_W-1:0] INSTR_BYPASS = 3'h7;
  // Fixed pattern loaded into the instruction shifter on capture
  localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;
  localparam logic BYPASS_CAPTURE_VAL = 1'b0;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map (byte addresses) and field positions
  localparam int AV_ADDR_W = 4;
  localparam int AV_DATA_W = 32;
  localparam logic [AV_ADDR_W-1:0] REG_STATUS = 4'h0;
  localparam logic [AV_ADDR_W-1:0] REG_LOG = 4'h4;
  localparam logic [AV_ADDR_W-1:0] REG_CTRL = 4'h8;
  localparam int STAT_TAP_LSB = 0;
  localparam int STAT_IR_LSB = 4;
  localparam int STAT_MODE_BIT = 7;
  localparam int STAT_LEVEL_LSB = 8;
  localparam int STAT_TDO_OE_BIT = 12;
  localparam int LOG_VALID_BIT = 8;
  localparam int CTRL_LOG_EN_BIT = 0;
  localparam logic CTRL_LOG_EN_RST = 1'b0;

  // Snapshot buffer shape
  localparam int LOG_DEPTH = 4;
  localparam int LOG_LEVEL_W = 3;

  ////////////////////////////////////////////////////////////////////////////////
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PA_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PA_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } bcc_tap_e;

  // Sequencing controls fanned out to every pad cell
  typedef struct packed {
    logic tck_rise;
    logic tck_fall;
    logic capture;
    logic shift_n;
    logic update;
    logic treset;
    logic mode;
  } bcc_cell_ctl_s;

  // Pad-side and core-side signals of one pad
  typedef struct packed {
    logic pad_out;
    logic pad_oe;
    logic core_in;
  } bcc_pad_drv_s;

  // Boundary chain owns the data path for EXTEST and SAMPLE only
  function automatic logic bcc_chain_sel(input logic [IR_W-1:0] instr);
    return (instr == INSTR_EXTEST) || (instr == INSTR_SAMPLE);
  endfunction : bcc_chain_sel

endpackage : bcc_pkg

// ===== tb.sv
// Testbench: drives the chain over its test port and its register bus
`timescale 1ns/10ps
module tb;
  logic clk, rst_n, tdo, tdo_oe, log_ready, tck, tms, tdi;
  logic avs_read, avs_write, avs_waitrequest;
  logic [3:0] pad_in, core_out, core_oe, pad_out, pad_oe, core_in, avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [7:0] d, v, u;
  logic [2:0] c;
  logic o;
  int n_fail, cmp_count, cyc;

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  bcc_chain_top DUT (.clk(clk), .rst_n(rst_n), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdo_oe(tdo_oe), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
    .core_out(core_out), .core_oe(core_oe), .core_in(core_in),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .log_ready(log_ready));
  bcc_host u_host (.clk(clk), .tdo(tdo), .tdo_oe(tdo_oe), .tck(tck), .tms(tms),
    .tdi(tdi));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] wd,
                    output logic [31:0] rd);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= wd;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : av

  // From idle: shift n bits, bit 0 first, and come back to idle
  task automatic scan(input logic ir, input int n, input logic [7:0] din,
                      output logic [7:0] dout);
    dout = 8'h00;
    u_host.step(1'b1, 1'b0, o);
    if (ir) u_host.step(1'b1, 1'b0, o);
    u_host.step(1'b0, 1'b0, o);
    u_host.step(1'b0, 1'b0, o);
    for (int k = 0; k < n; k++) begin
      u_host.step(k == n - 1, din[k], o);
      dout[k] = o;
      chk(tdo_oe, 1'b1);
    end
    u_host.step(1'b1, 1'b0, o);
    u_host.step(1'b0, 1'b0, o);
    chk(tdo_oe, 1'b0);
  endtask : scan

  function automatic logic [7:0] rev(input logic [7:0] x);
    for (int i = 0; i < 8; i++) rev[i] = x[7 - i];
  endfunction : rev

  // Direction bit of the last update picks core data or pad input
  function automatic logic [7:0] cap(input logic [7:0] x);
    for (int i = 0; i < 4; i++) begin
      cap[2 * i + 1] = x[2 * i + 1];
      cap[2 * i] = x[2 * i + 1] ? core_out[i] : pad_in[i];
    end
  endfunction : cap

  function automatic logic [3:0] pick(input logic [7:0] x, input int b);
    for (int i = 0; i < 4; i++) pick[i] = x[2 * i + b];
  endfunction : pick

  task automatic end_sim;
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_sim

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      end_sim;
    end
  end

  initial begin
    rst_n = 1'b0;
    pad_in = 4'ha;
    core_out = 4'h5;
    core_oe = 4'h3;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    av(1'b0, bcc_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q[7:0], 8'h70);
    chk({pad_out, pad_oe}, {core_out, core_oe});
    chk(core_in, pad_in);
    av(1'b0, 4'hc, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    av(1'b1, bcc_pkg::REG_CTRL, 32'h0000_0001, q);
    av(1'b0, bcc_pkg::REG_CTRL, 32'h0000_0000, q);
    chk(q, 32'h0000_0001);
    u_host.step(1'b0, 1'b0, o);
    for (int k = 0; k < 4; k++) begin
      c = (k == 0) ? bcc_pkg::INSTR_SAMPLE : (k == 1) ? bcc_pkg::INSTR_RESERVED :
          (k == 2) ? bcc_pkg::INSTR_BYPASS : bcc_pkg::INSTR_EXTEST;
      scan(1'b1, 3, {5'h00, c}, d);
      chk(d[2:0], bcc_pkg::IR_CAPTURE_VAL);
      av(1'b0, bcc_pkg::REG_STATUS, 32'h0000_0000, q);
      chk(q[7:0], {c == bcc_pkg::INSTR_EXTEST, c, 4'h1});
      if (k == 1 || k == 2) begin
        scan(1'b0, 8, 8'hb5, d);
        chk(d, 8'h6a);
        chk({pad_out, pad_oe}, {core_out, core_oe});
      end
    end
    u = 8'h00;
    chk(pad_oe, 4'h0);
    for (int k = 0; k < 2; k++) begin
      v = k ? 8'h5a : 8'h96;
      core_out <= k ? 4'hc : 4'h5;
      scan(1'b0, 8, rev(v), d);
      chk(rev(d), cap(u));
      chk({pad_out, pad_oe}, {pick(v, 0), pick(v, 1)});
      av(1'b0, bcc_pkg::REG_STATUS, 32'h0000_0000, q);
      chk(q[12:8], 5'h01);
      av(1'b0, bcc_pkg::REG_LOG, 32'h0000_0000, q);
      chk(q[8:0], {1'b1, v});
      u = v;
    end
    for (int k = 0; k < 5; k++) u_host.step(1'b1, 1'b0, o);
    av(1'b0, bcc_pkg::REG_STATUS, 32'h0000_0000, q);
    chk(q[12:0], 13'h0070);
    chk({pad_out, pad_oe}, {core_out, core_oe});
    chk(log_ready, 1'b1);
    end_sim;
  end
endmodule : tb
